// ===== shared/fms_defs.svh
// constants for the flash to mirror array playback sequencer
`ifndef FMS_DEFS_SVH
`define FMS_DEFS_SVH
`define FMS_RD_OPCODE    8'h0C
`define FMS_CMD_BYTES    5
`define FMS_DUMMY_BYTES  8
`define FMS_HDR_ADDR     32'h0000_0000
`define FMS_VID_STRIDE   32'h0100_0000
`define FMS_ARR_W        608
`define FMS_ARR_H        684
`define FMS_PLANES_DEF   20
`define FMS_FRAMES_DEF   500
`define FMS_CLK_HZ       25000000
`define FMS_FRAME_HZ     25
`define FMS_FRAME_CYC    (`FMS_CLK_HZ / `FMS_FRAME_HZ)
`define FMS_SHOW_US      1000
`define FMS_SHOW_CYC     ((`FMS_SHOW_US * (`FMS_CLK_HZ / 1000000)))
`define FMS_PARK_CYC     16
`define FMS_AUTOPLAY_BIT 0
`define FMS_PWM_RST      8'h80
`endif

// ===== shared/fms_pkg.sv
// types for the flash to mirror array playback sequencer
package fms_pkg;
   typedef enum logic [1:0] {OP_PLAY, OP_VIDEO, OP_TEMP, OP_CURRENT} fms_op_t;
   typedef struct packed {
      logic       valid;
      fms_op_t    op;
      logic [1:0] color;
      logic [7:0] arg;
   } fms_cmd_t;
   typedef struct packed {
      logic       master_en;
      logic [2:0] color_en;
      logic [2:0] pwm;
      logic [1:0] pwm_sel;
   } fms_illum_t;
   typedef struct packed {
      logic       cs_b;
      logic       sck;
      logic [7:0] dq_out;
      logic       dq_oe;
   } fms_flash_t;
   typedef enum {ST_BOOT, ST_CMD, ST_HDR, ST_IDLE, ST_WAITF, ST_LOAD, ST_SHOW,
                 ST_PARK, ST_OFF} fms_state_t;
endpackage

// ===== design/fms_sequencer.sv
// flash to mirror array playback sequencer with illumination control
`timescale 1ns/1ps
`include "fms_defs.svh"

// Overview of operation
// - after reset, fetch header without a host, then fetch content and load array if autoplay is set
// - on supply loss, run array park sequence immediately, no command needed
// - autoplay bit in flash header decides whether playback starts
// - each loaded plane lights its tied color during display
// - one master enable plus one enable per color
// - one pwm per color, two select bits steer active color's pwm
// - host commands: play, select video, read temperature, set current
// - content read over octal flash bus, one byte per clock of flash
// - run-length bytes expanded to native pixel stream before loading
// - every one of 608 by 684 mirrors gets data each plane
// - plane count per frame is read from header, not fixed
// - frame tick at 25 Hz; overrun flagged if loading misses it
module fms_sequencer
   import fms_pkg::*;
#(
   parameter int FRAME_CYC = `FMS_FRAME_CYC,
   parameter int SHOW_CYC  = `FMS_SHOW_CYC,
   parameter int FRAMES    = `FMS_FRAMES_DEF,
   parameter int ARR_W     = `FMS_ARR_W,
   parameter int ARR_H     = `FMS_ARR_H
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // flash
   output fms_flash_t      flash_o,
   input  wire logic [7:0] flash_dq_in,
   // mirror array
   output logic            arr_data,
   output logic            arr_valid,
   input  wire logic       arr_ready,
   output logic            arr_plane_first,
   output logic            arr_park,
   // host commands
   input  fms_cmd_t        cmd_i,
   input  wire logic [7:0] temp_in,
   output logic [7:0]      rsp_data,
   output logic            rsp_valid,
   // power and illumination
   input  wire logic       pwr_loss,
   output fms_illum_t      illum_o,
   output logic            overrun
);
   localparam int PIX = ARR_W * ARR_H;
   localparam int HDR_LAST = `FMS_CMD_BYTES + `FMS_DUMMY_BYTES + 1;

   fms_state_t  st_r;
   logic        ph_r, step, bus_go, byte_vld_r, take, consume;
   logic [4:0]  bcnt_r;
   logic [31:0] addr_r, base_r;
   logic [7:0]  cfg_r, planes_r, plane_r;
   logic [1:0]  color_r;
   logic        run_val_r;
   logic [7:0]  run_left_r, byte_r;
   logic [19:0] pix_r;
   logic [31:0] tmr_r, show_r, frame_idx_r;
   logic        tick, in_hdr_r;
   logic [7:0]  duty_r [3];
   logic [7:0]  pwm_cnt_r;
   wire  [2:0]  pwm_nxt, lit_nxt;

   // ----------------------------------------------------------------
   // flash bus sequencing
   // ----------------------------------------------------------------
   assign bus_go = (st_r == ST_CMD) || (st_r == ST_HDR)
                   || ((st_r == ST_LOAD) && !byte_vld_r);
   assign step   = clk_en && ph_r;
   assign take   = step && (st_r == ST_LOAD) && !byte_vld_r;
   assign consume = (st_r == ST_LOAD) && byte_vld_r && (run_left_r == 8'h00);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ph_r <= 1'b0;
      end else if (clk_en) begin
         ph_r <= bus_go ? !ph_r : 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flash_o <= '{cs_b: 1'b1, sck: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
      end else if (clk_en) begin
         flash_o.cs_b <= !(st_r == ST_CMD || st_r == ST_HDR || st_r == ST_LOAD);
         flash_o.sck  <= bus_go && !ph_r;
         flash_o.dq_oe <= (st_r == ST_CMD) && (bcnt_r < 5'(`FMS_CMD_BYTES));
         case (bcnt_r)
            5'd0:    flash_o.dq_out <= `FMS_RD_OPCODE;
            5'd1:    flash_o.dq_out <= addr_r[31:24];
            5'd2:    flash_o.dq_out <= addr_r[23:16];
            5'd3:    flash_o.dq_out <= addr_r[15:8];
            5'd4:    flash_o.dq_out <= addr_r[7:0];
            default: flash_o.dq_out <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // frame timer
   // ----------------------------------------------------------------
   assign tick = (tmr_r == 32'(FRAME_CYC - 1));
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tmr_r <= 32'h0000_0000;
      end else if (clk_en) begin
         tmr_r <= tick ? 32'h0000_0000 : tmr_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= ST_BOOT;
         bcnt_r <= 5'd0;
         addr_r <= `FMS_HDR_ADDR;
         base_r <= `FMS_VID_STRIDE;
         in_hdr_r <= 1'b1;
         cfg_r <= 8'h00;
         planes_r <= 8'(`FMS_PLANES_DEF);
         plane_r <= 8'h00;
         color_r <= 2'd0;
         byte_vld_r <= 1'b0;
         byte_r <= 8'h00;
         run_left_r <= 8'h00;
         run_val_r <= 1'b0;
         pix_r <= 20'h0_0000;
         show_r <= 32'h0000_0000;
         frame_idx_r <= 32'h0000_0000;
         overrun <= 1'b0;
      end else if (clk_en) begin
         if (pwr_loss && st_r != ST_PARK && st_r != ST_OFF) begin
            st_r <= ST_PARK;
            show_r <= 32'h0000_0000;
         end else begin
            case (st_r)
               ST_BOOT: begin
                  st_r <= ST_CMD;
                  bcnt_r <= 5'd0;
               end
               ST_CMD: if (step) begin
                  bcnt_r <= bcnt_r + 5'd1;
                  if (bcnt_r == 5'(`FMS_CMD_BYTES + `FMS_DUMMY_BYTES - 1)) begin
                     st_r <= in_hdr_r ? ST_HDR : ST_LOAD;
                  end
               end
               ST_HDR: if (step) begin
                  bcnt_r <= bcnt_r + 5'd1;
                  if (bcnt_r == 5'(HDR_LAST - 1)) begin
                     cfg_r <= flash_dq_in;
                  end else begin
                     planes_r <= (flash_dq_in == 8'h00) ? 8'h01 : flash_dq_in;
                     in_hdr_r <= 1'b0;
                     addr_r <= base_r;
                     st_r <= cfg_r[`FMS_AUTOPLAY_BIT] ? ST_WAITF : ST_IDLE;
                  end
               end
               ST_IDLE: begin
                  if (cmd_i.valid && cmd_i.op == OP_PLAY) begin
                     st_r <= ST_WAITF;
                  end
               end
               ST_WAITF: begin
                  if (cmd_i.valid && cmd_i.op == OP_VIDEO) begin
                     base_r <= 32'(cmd_i.arg + 9'd1) * `FMS_VID_STRIDE;
                     addr_r <= 32'(cmd_i.arg + 9'd1) * `FMS_VID_STRIDE;
                     frame_idx_r <= 32'h0000_0000;
                  end else if (tick) begin
                     st_r <= ST_CMD;
                     bcnt_r <= 5'd0;
                     plane_r <= 8'h00;
                     color_r <= 2'd0;
                  end
               end
               ST_LOAD: begin
                  if (tick) begin
                     overrun <= 1'b1;
                  end
                  if (take) begin
                     byte_r <= flash_dq_in;
                     byte_vld_r <= 1'b1;
                  end
                  if (consume) begin
                     run_val_r <= byte_r[7];
                     run_left_r <= {1'b0, byte_r[6:0]} + 8'd1;
                     byte_vld_r <= 1'b0;
                     addr_r <= addr_r + 32'h0000_0001;
                  end
                  if (arr_valid && arr_ready) begin
                     run_left_r <= run_left_r - 8'd1;
                     if (pix_r == 20'(PIX - 1)) begin
                        pix_r <= 20'h0_0000;
                        run_left_r <= 8'h00;
                        byte_vld_r <= 1'b0;
                        show_r <= 32'h0000_0000;
                        st_r <= ST_SHOW;
                     end else begin
                        pix_r <= pix_r + 20'h0_0001;
                     end
                  end
               end
               ST_SHOW: begin
                  show_r <= show_r + 32'h0000_0001;
                  if (show_r == 32'(SHOW_CYC - 1)) begin
                     color_r <= (color_r == 2'd2) ? 2'd0 : color_r + 2'd1;
                     bcnt_r <= 5'd0;
                     if (plane_r == planes_r - 8'h01) begin
                        st_r <= ST_WAITF;
                        frame_idx_r <= frame_idx_r + 32'h0000_0001;
                        if (frame_idx_r == 32'(FRAMES - 1)) begin
                           frame_idx_r <= 32'h0000_0000;
                           addr_r <= base_r;
                        end
                     end else begin
                        plane_r <= plane_r + 8'h01;
                        st_r <= ST_CMD;
                     end
                  end
               end
               ST_PARK: begin
                  show_r <= show_r + 32'h0000_0001;
                  if (show_r == 32'(`FMS_PARK_CYC - 1)) begin
                     st_r <= ST_OFF;
                  end
               end
               ST_OFF: st_r <= ST_OFF;
               default: st_r <= ST_BOOT;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // array pixel stream
   // ----------------------------------------------------------------
   assign arr_valid       = (st_r == ST_LOAD) && (run_left_r != 8'h00);
   assign arr_data        = run_val_r;
   assign arr_plane_first = arr_valid && (pix_r == 20'h0_0000);
   assign arr_park        = (st_r == ST_PARK);

   // ----------------------------------------------------------------
   // host replies and led current
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rsp_data <= 8'h00;
         rsp_valid <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= cmd_i.valid && cmd_i.op == OP_TEMP;
         if (cmd_i.valid && cmd_i.op == OP_TEMP) begin
            rsp_data <= temp_in;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pwm_cnt_r <= 8'h00;
      end else if (clk_en) begin
         pwm_cnt_r <= pwm_cnt_r + 8'h01;
      end
   end

   // one duty register and one pwm pin per color
   for (genvar c = 0; c < 3; c++) begin : g_pwm
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            duty_r[c] <= `FMS_PWM_RST;
         end else if (clk_en && cmd_i.valid && cmd_i.op == OP_CURRENT
                      && cmd_i.color == 2'(c)) begin
            duty_r[c] <= cmd_i.arg;
         end
      end
      assign pwm_nxt[c] = pwm_cnt_r < duty_r[c];
      assign lit_nxt[c] = (st_r == ST_SHOW) && !pwr_loss && (color_r == 2'(c));
   end

   // all illumination pins leave one register so they switch together
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         illum_o <= '0;
      end else if (clk_en) begin
         illum_o.pwm <= pwm_nxt;
         illum_o.color_en <= lit_nxt;
         illum_o.master_en <= !pwr_loss && st_r inside {ST_WAITF, ST_CMD, ST_LOAD, ST_SHOW};
         illum_o.pwm_sel <= color_r;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_park_enter: assert property (clk_en && pwr_loss && !(st_r inside {ST_PARK, ST_OFF})
      |=> st_r == ST_PARK) else $error("no park after supply loss");
   chk_park_dark: assert property (st_r inside {ST_PARK, ST_OFF}
      |=> illum_o.master_en == 1'b0 && illum_o.color_en == 3'b000)
      else $error("light on while parked");
   chk_boot_go: assert property ($rose(rst_b) && clk_en |=> st_r == ST_CMD)
      else $error("no self start");
   chk_one_color: assert property ($onehot0(illum_o.color_en))
      else $error("two colors lit");
   chk_color_tied: assert property (clk_en && st_r == ST_SHOW && !pwr_loss
      |=> illum_o.color_en[illum_o.pwm_sel]) else $error("wrong color lit");
   chk_color_master: assert property (illum_o.color_en != 3'b000 |-> illum_o.master_en)
      else $error("color without master");
   chk_pix_range: assert property (pix_r < 20'(PIX)) else $error("pixel count overflow");
   chk_plane_done: assert property (clk_en && st_r == ST_LOAD && !pwr_loss && arr_valid
      && arr_ready && pix_r == 20'(PIX - 1) |=> st_r == ST_SHOW)
      else $error("plane end missed");
   chk_autoplay: assert property (clk_en && st_r == ST_HDR && step && !pwr_loss
      && bcnt_r != 5'(HDR_LAST - 1) |=> st_r == (cfg_r[0] ? ST_WAITF : ST_IDLE))
      else $error("start-up setting ignored");
   chk_temp_rsp: assert property (clk_en && cmd_i.valid && cmd_i.op == OP_TEMP
      |=> rsp_valid && rsp_data == $past(temp_in)) else $error("temperature reply wrong");
   chk_run_expand: assert property (clk_en && consume && !pwr_loss && !(arr_valid && arr_ready)
      |=> run_left_r == {1'b0, $past(byte_r[6:0])} + 8'd1)
      else $error("run length wrong");

   cov_play: cover property (st_r == ST_WAITF ##1 st_r == ST_CMD);
   cov_show: cover property (st_r == ST_SHOW);
   cov_park: cover property (st_r == ST_PARK ##[1:40] st_r == ST_OFF);
endmodule

// ===== bench/fms_flash_model.sv
// behavioural octal flash holding a header and run-length content
`timescale 1ns/1ps

module fms_flash_model
   import fms_pkg::*;
(
   // flash pins
   input  fms_flash_t      flash_i,
   output logic [7:0]      dq_in,
   // image contents
   input  wire logic       auto_play,
   input  wire logic [7:0] n_planes
);
   // -------------------------------------------------------------
   // image and byte stream
   // -------------------------------------------------------------
   int          cnt;
   logic [31:0] addr_r;
   logic [7:0]  last;

   // runs of four pixels, value flips every byte and with address bit 25
   function automatic logic [7:0] image_byte(input logic [31:0] a);
      if (a == 32'h0000_0000) return {7'h00, auto_play};
      if (a == 32'h0000_0001) return n_planes;
      return {a[0] ^ a[25], 7'h03};
   endfunction

   initial begin
      cnt = 0;
      addr_r = '0;
      last = 8'h00;
      dq_in = 8'hff;
   end

   // data is set as sck rises so it is stable while sck is high
   always @(posedge flash_i.sck or posedge flash_i.cs_b) begin
      if (flash_i.cs_b) begin
         cnt = 0;
         dq_in = ~last;
      end else begin
         if (cnt >= 1 && cnt <= 4) addr_r = {addr_r[23:0], flash_i.dq_out};
         if (cnt >= 13) begin
            last = image_byte(addr_r + 32'(cnt - 13));
            dq_in = last;
         end else begin
            // not driven during command and dummy bytes
            dq_in = ~dq_in;
         end
         cnt++;
      end
   end
endmodule

// ===== bench/fms_sequencer_tb.sv
// self-checking testbench for the playback sequencer
`timescale 1ns/1ps
`include "fms_defs.svh"

module fms_sequencer_tb
   import fms_pkg::*;
;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   localparam int PIX = 32;
   logic       core_clk  = 1'b0;
   logic       rst_b     = 1'b0;
   logic       clk_en    = 1'b1;
   logic       arr_ready = 1'b0;
   logic       pwr_loss  = 1'b0;
   logic       auto_play = 1'b1;
   logic [7:0] n_planes  = 8'h03;
   logic [7:0] temp_in   = 8'h00;
   fms_cmd_t   cmd_i     = '0;
   fms_flash_t flash;
   fms_illum_t illum;
   logic [7:0] dq_in;
   logic [7:0] rsp_data;
   logic       arr_data, arr_valid, arr_plane_first, arr_park, rsp_valid, overrun;
   int         n_errors  = 0;
   int         tests_run = 0;

   always #20 core_clk = ~core_clk;

   fms_sequencer #(.FRAME_CYC(2000), .SHOW_CYC(4), .FRAMES(2), .ARR_W(8), .ARR_H(4)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .flash_o(flash), .flash_dq_in(dq_in),
      .arr_data(arr_data), .arr_valid(arr_valid), .arr_ready(arr_ready),
      .arr_plane_first(arr_plane_first), .arr_park(arr_park),
      .cmd_i(cmd_i), .temp_in(temp_in), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .pwr_loss(pwr_loss), .illum_o(illum), .overrun(overrun));

   fms_flash_model flash_mem (
      .flash_i(flash), .dq_in(dq_in), .auto_play(auto_play), .n_planes(n_planes));

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic do_reset(input logic ap);
      @(posedge core_clk);
      rst_b <= 1'b0;
      auto_play <= ap;
      arr_ready <= 1'b0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      check(flash.cs_b, 1);
      check(illum, 0);
      check(arr_valid, 0);
      @(posedge core_clk);
      rst_b <= 1'b1;
   endtask

   task automatic send_cmd(input fms_op_t op, input logic [1:0] col, input logic [7:0] arg);
      @(posedge core_clk);
      cmd_i <= '{valid: 1'b1, op: op, color: col, arg: arg};
      @(posedge core_clk);
      cmd_i <= '0;
   endtask

   // first pixel is held in a stall, then the plane streams and is shown
   task automatic take_plane(input logic inv, input int col);
      int w;
      int n;
      w = 0;
      while (!(arr_valid === 1'b1 && arr_plane_first === 1'b1) && w < 3000) begin
         @(negedge core_clk);
         w++;
      end
      check(w < 3000, 1);
      repeat (3) @(negedge core_clk);
      check({arr_valid, arr_plane_first, arr_data}, {2'b11, inv});
      @(posedge core_clk);
      arr_ready <= 1'b1;
      @(negedge core_clk);
      for (n = 0; n < PIX; n++) begin
         w = 0;
         while (arr_valid !== 1'b1 && w < 200) begin
            @(negedge core_clk);
            w++;
         end
         check(arr_data, n[2] ^ inv);
         if (n < PIX - 1) @(negedge core_clk);
      end
      @(posedge core_clk);
      arr_ready <= 1'b0;
      w = 0;
      while (illum.color_en === 3'b000 && w < 200) begin
         @(negedge core_clk);
         w++;
      end
      check(illum.color_en, 3'b001 << col);
      check(illum.pwm_sel, col);
      check(illum.master_en, 1);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic s_autoplay();
      int w;
      do_reset(1'b1);
      w = 0;
      while (flash.cs_b !== 1'b0 && w < 20) begin
         @(negedge core_clk);
         w++;
      end
      check(flash.cs_b, 0);
      check({flash.dq_oe, flash.dq_out}, {1'b1, `FMS_RD_OPCODE});
      take_plane(1'b0, 0);
      take_plane(1'b0, 1);
      take_plane(1'b0, 2);
      // three planes from the header, then the next frame starts over
      take_plane(1'b0, 0);
   endtask

   task automatic s_host();
      int seen;
      int hi1;
      int hi2;
      do_reset(1'b0);
      seen = 0;
      repeat (1500) begin
         @(negedge core_clk);
         if (arr_valid !== 1'b0) seen++;
      end
      check(seen, 0);
      @(posedge core_clk);
      temp_in <= 8'h5a;
      send_cmd(OP_TEMP, 2'd0, 8'h00);
      @(negedge core_clk);
      check({rsp_valid, rsp_data}, 9'h15a);
      @(negedge core_clk);
      check(rsp_valid, 0);
      // a command given while the clock enable is low must be lost
      @(posedge core_clk);
      clk_en <= 1'b0;
      temp_in <= 8'ha5;
      send_cmd(OP_TEMP, 2'd0, 8'h00);
      repeat (2) @(negedge core_clk);
      check({rsp_valid, rsp_data}, 9'h05a);
      @(posedge core_clk);
      clk_en <= 1'b1;
      send_cmd(OP_CURRENT, 2'd1, 8'h40);
      repeat (4) @(negedge core_clk);
      hi1 = 0;
      hi2 = 0;
      repeat (256) begin
         @(negedge core_clk);
         if (illum.pwm[1] === 1'b1) hi1++;
         if (illum.pwm[2] === 1'b1) hi2++;
      end
      check(hi1, 64);
      check(hi2, 128);
      send_cmd(OP_PLAY, 2'd0, 8'h00);
      send_cmd(OP_VIDEO, 2'd0, 8'h01);
      take_plane(1'b1, 0);
      check(overrun, 0);
   endtask

   task automatic s_overrun();
      // array held off past a frame tick while a plane is loading
      repeat (2100) @(negedge core_clk);
      check(overrun, 1);
   endtask

   task automatic s_power();
      int w;
      int c;
      @(posedge core_clk);
      pwr_loss <= 1'b1;
      w = 0;
      while (arr_park !== 1'b1 && w < 4) begin
         @(negedge core_clk);
         w++;
      end
      check(arr_park, 1);
      check({illum.master_en, illum.color_en}, 0);
      c = 0;
      while (arr_park === 1'b1 && c < 40) begin
         @(negedge core_clk);
         c++;
      end
      check(c, 16);
      repeat (50) @(negedge core_clk);
      check({arr_park, illum.master_en, illum.color_en}, 0);
   endtask

   // -------------------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      s_autoplay();
      s_host();
      s_overrun();
      s_power();
      results();
   end

   // the whole run needs well under 20000 cycles
   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      results();
   end
endmodule
